// ===== pkg/wcw_pkg.sv
// Package for the windowed countdown watchdog: register map, fields, timing
package wcw_pkg;
  // APB register map (printed offset 0Dh is not a multiple of four: index)
  localparam logic [7:0] WCW_CTRL_INDEX = 8'h0d;
  localparam logic [7:0] WCW_CTRL_ADDR = 8'h34;
  localparam logic [7:0] WCW_STAT_ADDR = 8'h38;
  // Control register fields and reset value
  localparam int WCW_ACT_BIT = 7;
  localparam int WCW_TOP_BIT = 6;
  localparam logic [7:0] WCW_CTRL_RESET = 8'h7f;
  localparam logic [6:0] WCW_CNT_TRIP = 7'h40;
  // Status register fields
  localparam int WCW_ST_HALT_BIT = 0;
  localparam int WCW_ST_HOLD_BIT = 1;
  localparam int WCW_ST_VARIANT_BIT = 2;
  localparam int WCW_ST_CAUSE_BIT = 3;
  // Timing
  localparam int WCW_CLK_HZ = 10000000;
  localparam int WCW_WAKE_CYCLES = 514;
  localparam logic [9:0] WCW_WAKE_CNT = 10'(WCW_WAKE_CYCLES);
  localparam int WCW_TICK_DEF = 64;
  localparam int WCW_RST_PULSE_NS = 1000;
  localparam logic [3:0] WCW_RST_PULSE_CNT = 4'((WCW_RST_PULSE_NS * (WCW_CLK_HZ / 1000000) + 999) / 1000);

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [31:0] wdata;
  } wcw_req_t;

  typedef enum logic [1:0] {
    WCW_RUN = 2'b00,
    WCW_HALTED = 2'b01,
    WCW_WAKE = 2'b10
  } wcw_mode_t;
endpackage

// ===== src/wcw_core.sv
// Windowed countdown watchdog core with APB slave
//
// The APB register port was decided locally.
`timescale 1ns/100ps
// Functional notes
// - Software variant leaves every reset with the watchdog inactive.
// - Once active, writes cannot deactivate; only reset clears activation.
// - Writing activate set with top count bit clear forces immediate reset, except in halt or the wake delay.
// - Hardware variant runs and resets outside halt and the wake delay; activation bit ignored.
// - Wait state has no effect on counting or timeout.
// - Halted oscillator holds the counter and blocks timeout resets.
// - After external-interrupt wake, counting resumes only after 514 clocks.
// - Reset during halt returns software variant to inactive state.
// - Activation bit set only by software writes, cleared only by reset.
// - Software variant resets only while activation bit reads one.
// - Low seven control bits hold the counter, read and written there.
// - Active counter passing 40h to 3Fh issues a watchdog reset.
// - Control register at index 0Dh resets to 7Fh.
// - Watchdog reset drives the reset pin low for other devices.
module wcw_core
  import wcw_pkg::*;
#(
  parameter int TICK_CYCLES = WCW_TICK_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hw_variant,
  input wire logic wait_mode,
  input wire logic halt_req,
  input wire logic ext_wake,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wdg_reset,
  output logic reset_pin_out,
  output logic reset_pin_oe
);
  import wcw_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] hwv_sync_reg;
  logic [1:0] halt_sync_reg;
  logic [1:0] wake_sync_reg;
  logic hw_mode;
  logic halt_s;
  logic wake_s;

  // Strap and pins are asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hwv_sync_reg <= 2'b00;
      halt_sync_reg <= 2'b00;
      wake_sync_reg <= 2'b00;
    end else begin
      hwv_sync_reg <= {hwv_sync_reg[0], hw_variant};
      halt_sync_reg <= {halt_sync_reg[0], halt_req};
      wake_sync_reg <= {wake_sync_reg[0], ext_wake};
    end
  end

  assign hw_mode = hwv_sync_reg[1];
  assign halt_s = halt_sync_reg[1];
  assign wake_s = wake_sync_reg[1];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wcw_req_t req;
  logic acc;
  logic hit_ctrl;
  logic hit_stat;
  logic ctrl_wr;

  assign req = '{addr: paddr[7:0], write: pwrite, wdata: pwdata};
  assign acc = psel && penable;
  assign hit_ctrl = (paddr[31:8] == 24'h000000) && (req.addr == WCW_CTRL_ADDR);
  assign hit_stat = (paddr[31:8] == 24'h000000) && (req.addr == WCW_STAT_ADDR);
  assign ctrl_wr = acc && req.write && hit_ctrl && pstrb[0];
  // Zero wait states; unmapped and status writes answer with an error
  assign pready = 1'b1;
  assign pslverr = acc && !(hit_ctrl || (hit_stat && !req.write));

  // ----------------------------------------------------------------
  // Mode sequencing: run, halted, wake delay
  // ----------------------------------------------------------------
  wcw_mode_t mode_reg;
  logic [9:0] wake_cnt_reg;

  // Wait mode is not an input to this logic at all
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= WCW_RUN;
      wake_cnt_reg <= 10'h000;
    end else begin
      unique case (mode_reg)
        WCW_RUN: begin
          if (halt_s) begin
            mode_reg <= WCW_HALTED;
          end
        end
        WCW_HALTED: begin
          if (wake_s) begin
            mode_reg <= WCW_WAKE;
            wake_cnt_reg <= WCW_WAKE_CNT;
          end
        end
        WCW_WAKE: begin
          if (wake_cnt_reg == 10'h001) begin
            mode_reg <= WCW_RUN;
          end
          wake_cnt_reg <= wake_cnt_reg - 10'h001;
        end
        default: begin
          mode_reg <= WCW_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control register: activation and count
  // ----------------------------------------------------------------
  logic act_reg;
  logic [6:0] cnt_reg;
  logic running;
  logic armed;
  logic tick;
  logic trip;
  logic soft_trip;

  // Frozen in halt and through the wake delay
  assign running = (mode_reg == WCW_RUN);
  // Hardware variant ignores the activation bit
  assign armed = hw_mode || act_reg;

  wcw_tick_div #(
    .TICK(TICK_CYCLES)
  ) u_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(running && armed),
    .tick(tick)
  );

  // Activation is set-only; any reset clears it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_reg <= WCW_CTRL_RESET[WCW_ACT_BIT];
    end else if (ctrl_wr && req.wdata[WCW_ACT_BIT]) begin
      act_reg <= 1'b1;
    end
  end

  // Software write wins over a same-cycle tick
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= WCW_CTRL_RESET[6:0];
    end else if (ctrl_wr) begin
      cnt_reg <= req.wdata[6:0];
    end else if (tick) begin
      cnt_reg <= cnt_reg - 7'h01;
    end
  end

  // Roll from 40h to 3Fh while counting
  assign trip = tick && !ctrl_wr && (cnt_reg == WCW_CNT_TRIP);
  // Write with activate set and top bit clear hw variant too
  assign soft_trip = ctrl_wr && !req.wdata[WCW_TOP_BIT] && (req.wdata[WCW_ACT_BIT] || hw_mode);

  // ----------------------------------------------------------------
  // Reset output pulse
  // ----------------------------------------------------------------
  logic [3:0] pulse_reg;
  logic cause_reg;

  // Pulse stretched so board devices see a clean low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_reg <= 4'h0;
    end else if (trip || (soft_trip && running)) begin
      pulse_reg <= WCW_RST_PULSE_CNT;
    end else if (pulse_reg != 4'h0) begin
      pulse_reg <= pulse_reg - 4'h1;
    end
  end

  // Sticky cause flag for software after a partial reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= 1'b0;
    end else if (pulse_reg != 4'h0) begin
      cause_reg <= 1'b1;
    end
  end

  // Only a reset leaves the block; no interrupt line exists
  assign wdg_reset = (pulse_reg != 4'h0);
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = wdg_reset;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (hit_ctrl) begin
        prdata[7:0] <= {act_reg, cnt_reg};
      end else if (hit_stat) begin
        prdata[WCW_ST_HALT_BIT] <= (mode_reg == WCW_HALTED);
        prdata[WCW_ST_HOLD_BIT] <= (mode_reg == WCW_WAKE);
        prdata[WCW_ST_VARIANT_BIT] <= hw_mode;
        prdata[WCW_ST_CAUSE_BIT] <= cause_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Cycles spent in the wake hold; a counter keeps the check cheap for the tools
  logic [9:0] wake_seen_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_seen_reg <= 10'h000;
    end else if (mode_reg == WCW_WAKE) begin
      wake_seen_reg <= wake_seen_reg + 10'h001;
    end else begin
      wake_seen_reg <= 10'h000;
    end
  end

  AST_SW_NO_RESET_INACTIVE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!hw_mode && !act_reg && !$past(ctrl_wr)) |-> !$rose(wdg_reset))
    else $error("watchdog reset while inactive");
  AST_ACT_STICKY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    act_reg |=> act_reg)
    else $error("activation bit dropped");
  AST_ACT_SET_BY_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl_wr && req.wdata[WCW_ACT_BIT]) |=> act_reg)
    else $error("activation write ignored");
  AST_TRIP_RESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (tick && !ctrl_wr && cnt_reg == 7'h40) |=> (wdg_reset && cnt_reg == 7'h3f))
    else $error("no reset on 40h to 3Fh");
  AST_SOFT_RESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl_wr && running && req.wdata[7] && !req.wdata[6]) |=> wdg_reset)
    else $error("forced reset missing");
  AST_HALT_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_reg == WCW_HALTED && !ctrl_wr) |=> $stable(cnt_reg))
    else $error("counter moved in halt");
  AST_WAKE_DELAY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_reg == WCW_HALTED && wake_s) |=> (mode_reg == WCW_WAKE)[*8] ##0 !tick)
    else $error("counting resumed early");
  AST_WAKE_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_reg == WCW_WAKE && wake_seen_reg == WCW_WAKE_CNT - 10'h001) |=> (mode_reg == WCW_RUN))
    else $error("wake delay not 514 clocks");
  AST_WAKE_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_reg == WCW_WAKE && wake_seen_reg < WCW_WAKE_CNT - 10'h001) |=> (mode_reg == WCW_WAKE))
    else $error("wake delay ended early");
  AST_PIN_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wdg_reset |-> (reset_pin_oe && !reset_pin_out))
    else $error("reset pin not driven low");
  AST_HW_RUNS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (hw_mode && running && tick && !ctrl_wr) |=> (cnt_reg == $past(cnt_reg) - 7'h01))
    else $error("hardware variant not counting");

  COV_TIMEOUT: cover property (@(posedge ref_clk) disable iff (!rst_n) trip);
  COV_SOFT: cover property (@(posedge ref_clk) disable iff (!rst_n) soft_trip && running);
  COV_WAKE: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(mode_reg == WCW_WAKE));
endmodule

// ===== src/wcw_tick_div.sv
// Tick divider: one-cycle enable every TICK cycles while running
`timescale 1ns/100ps
module wcw_tick_div #(
  parameter int TICK = 64
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);
  logic [15:0] div_reg;

  // Prescaler restarts when paused so a wake-up gets a full first period
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 16'h0000;
    end else if (!run) begin
      div_reg <= 16'h0000;
    end else if (div_reg == 16'(TICK - 1)) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  assign tick = run && (div_reg == 16'(TICK - 1));
endmodule

// ===== tb/wcw_core_tb.sv
// Self-checking bench for the windowed countdown watchdog core
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module wcw_core_tb;
  import wcw_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hw_variant = 1'b0;
  logic wait_mode = 1'b0;
  logic halt_req = 1'b0;
  logic ext_wake = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wdg_reset;
  logic reset_pin_out;
  logic reset_pin_oe;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int checks = 0;
  int n;

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  // Short tick keeps each timeout to a few dozen cycles
  wcw_core #(.TICK_CYCLES(4)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .hw_variant(hw_variant), .wait_mode(wait_mode),
    .halt_req(halt_req), .ext_wake(ext_wake), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdg_reset(wdg_reset),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hung waits count as a mismatch and close the run
  task automatic give_up(input int lim);
    mismatches++;
    $display("mismatch timeout exp %0d got %0d", lim, n);
    report_and_stop();
  endtask

  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) give_up(20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  // No watchdog reset may appear for c cycles
  task automatic quiet(input int c);
    repeat (c) begin
      @(posedge ref_clk);
      `CHK("wdg_reset", 1'b0, wdg_reset)
    end
  endtask

  // Waits for a watchdog reset, then checks pin drive and pulse length
  task automatic trip(input int lim);
    int w;
    n = 0;
    while (wdg_reset !== 1'b1) begin
      @(posedge ref_clk);
      n++;
      if (n > lim) give_up(lim);
    end
    `CHK("reset_pin_oe", 1'b1, reset_pin_oe)
    `CHK("reset_pin_out", 1'b0, reset_pin_out)
    w = 0;
    while (wdg_reset === 1'b1 && w < 40) begin
      @(posedge ref_clk);
      w++;
    end
    `CHK("pulse", int'(WCW_RST_PULSE_CNT), w)
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    apb(1'b0, WCW_CTRL_ADDR, 8'h00);
    `CHK("ctrl", 32'h7f, rd)
    apb(1'b0, 8'h00, 8'h00);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, WCW_STAT_ADDR, 8'hff);
    `CHK("stat_wr", 1'b1, err)
    // Disabled byte lane must not arm the watchdog
    pstrb <= 4'h0;
    apb(1'b1, WCW_CTRL_ADDR, 8'hc0);
    pstrb <= 4'hf;
    apb(1'b0, WCW_CTRL_ADDR, 8'h00);
    `CHK("ctrl", 32'h7f, rd)
    // Inactive: top bit clear but nothing happens, count holds
    apb(1'b1, WCW_CTRL_ADDR, 8'h3f);
    quiet(40);
    apb(1'b0, WCW_CTRL_ADDR, 8'h00);
    `CHK("ctrl", 32'h3f, rd)
    // Armed in wait state; clearing the activate bit is ignored
    wait_mode <= 1'b1;
    apb(1'b1, WCW_CTRL_ADDR, 8'hc6);
    apb(1'b1, WCW_CTRL_ADDR, 8'h46);
    apb(1'b0, WCW_CTRL_ADDR, 8'h00);
    `CHK("act", 1'b1, rd[WCW_ACT_BIT])
    trip(40);
    apb(1'b0, WCW_STAT_ADDR, 8'h00);
    `CHK("cause", 1'b1, rd[WCW_ST_CAUSE_BIT])
    wait_mode <= 1'b0;
    // Forced reset by software
    do_reset();
    apb(1'b1, WCW_CTRL_ADDR, 8'h80);
    trip(5);
    // Halt holds the count; wake waits the resume delay
    do_reset();
    halt_req <= 1'b1;
    repeat (5) @(posedge ref_clk);
    apb(1'b1, WCW_CTRL_ADDR, 8'hc1);
    quiet(60);
    apb(1'b0, WCW_CTRL_ADDR, 8'h00);
    `CHK("ctrl", 32'hc1, rd)
    ext_wake <= 1'b1;
    halt_req <= 1'b0;
    quiet(4);
    ext_wake <= 1'b0;
    quiet(480);
    apb(1'b0, WCW_CTRL_ADDR, 8'h00);
    `CHK("ctrl", 32'hc1, rd)
    trip(60);
    // Reset while halted returns to inactive
    do_reset();
    apb(1'b1, WCW_CTRL_ADDR, 8'hc1);
    halt_req <= 1'b1;
    repeat (5) @(posedge ref_clk);
    do_reset();
    halt_req <= 1'b0;
    apb(1'b0, WCW_CTRL_ADDR, 8'h00);
    `CHK("ctrl", 32'h7f, rd)
    // Hardware variant runs without the activate bit
    hw_variant <= 1'b1;
    do_reset();
    apb(1'b1, WCW_CTRL_ADDR, 8'h46);
    trip(60);
    report_and_stop();
  end
endmodule
